// ===== freq_wdt_pkg.sv
// Package: register layout, reset values and timing constants
package freq_wdt_pkg;

    // Clock rate and prescaler time units
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned UNIT_SHORT_MS    = 150;
    localparam int unsigned UNIT_LONG_MS     = 2500;
    localparam int unsigned UNIT_SHORT_CYC   = UNIT_SHORT_MS * 1000 * CLK_MHZ;
    localparam int unsigned UNIT_LONG_CYC    = UNIT_LONG_MS * 1000 * CLK_MHZ;
    localparam int unsigned RESET_PULSE_CYC  = 16;

    // Byte offsets of the control bytes on the register port
    localparam logic [4:0] OFF_CTRL          = 5'h00;
    localparam logic [4:0] OFF_SELECT        = 5'h01;
    localparam logic [4:0] OFF_WDT           = 5'h02;
    localparam logic [4:0] OFF_REC_N         = 5'h03;
    localparam logic [4:0] OFF_REC_M         = 5'h04;
    localparam logic [4:0] OFF_CPU_N         = 5'h05;
    localparam logic [4:0] OFF_CPU_M         = 5'h06;
    localparam logic [4:0] OFF_STRAPS        = 5'h07;

    // Bit positions inside the control byte
    localparam int unsigned BIT_OVERRIDE     = 0;
    localparam int unsigned BIT_REC_SRC      = 1;
    localparam int unsigned BIT_WATCHDOG_ENABLE        = 2;
    localparam int unsigned BIT_WD_FLAG      = 3;
    localparam int unsigned BIT_UNIT_SEL     = 4;
    localparam int unsigned BIT_RST_WD       = 5;
    localparam int unsigned BIT_RST_FC       = 6;
    // Bit position of enable in the cpu_m byte
    localparam int unsigned BIT_PROG_EN      = 7;

    // Reset values
    localparam logic [7:0] CTRL_RST          = 8'h00;
    localparam logic [4:0] TIMEOUT_RST       = 5'h1f;

    // Where the output frequency comes from
    typedef struct packed {
        logic       use_dividers;
        logic [4:0] ratio_select;
        logic [7:0] numerator;
        logic [6:0] denominator;
    } freq_setting_t;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// ===== prog_freq_watchdog_recovery.sv
// Frequency selection, watchdog and recovery control
`timescale 1ns/10ps
`default_nettype none
module prog_freq_watchdog_recovery (
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic [4:0]              strap_select_inputs,
    input  wire freq_wdt_pkg::reg_req_t  reg_req,
    output logic [7:0]                   reg_rdata,
    output freq_wdt_pkg::freq_setting_t  freq_out,
    output logic                         freq_load,
    output logic                         in_recovery,
    output logic                         system_reset
);
    // Synchronised straps and latched copy
    logic [4:0] strap_s1_reg;
    logic [4:0] strap_s2_reg;
    logic [4:0] strap_latch_reg;
    logic       strap_done_reg;

    // Control state
    logic       select_source_override_reg;
    logic       recovery_source_select_reg;
    logic       watchdog_enable_reg;
    logic       watchdog_timeout_flag_reg;
    logic       watchdog_unit_select_reg;
    logic       reset_on_timeout_enable_reg;
    logic       reset_on_freq_change_enable_reg;
    logic       prog_enable_reg;
    logic [4:0] select_field_reg;
    logic [4:0] watchdog_timeout_value_reg;
    logic [7:0] cpu_divider_numerator_reg;
    logic [6:0] cpu_divider_denominator_reg;
    logic [7:0] recovery_divider_numerator_reg;
    logic [6:0] recovery_divider_denominator_reg;
    logic       recovery_reg;

    // Output registers
    logic [7:0] rdata_reg;
    freq_wdt_pkg::freq_setting_t freq_reg;
    logic       load_reg;
    logic       sysrst_reg;

    // Decoded writes
    logic       wr_ctrl;
    logic       wr_sel;
    logic       wr_wdt;
    logic       wr_rec_n;
    logic       wr_rec_m;
    logic       wr_cpu_n;
    logic       wr_cpu_m;
    logic       normal_load;
    logic       recovery_load;
    logic       timeout_evt;
    logic       freq_change;
    logic       pulse;
    logic       wdt_running;
    logic [4:0] ratio_src;
    freq_wdt_pkg::freq_setting_t normal_set;
    freq_wdt_pkg::freq_setting_t recovery_set;
    freq_wdt_pkg::freq_setting_t load_set;
    logic       load_now;
    logic       pulse_req;
    logic       override_next;
    logic       rec_src_next;
    logic       prog_enable_next;
    logic [4:0] select_next;
    logic [7:0] cpu_n_next;
    logic [6:0] cpu_m_next;
    logic [7:0] rec_n_next;
    logic [6:0] rec_m_next;
    logic [7:0] rd_mux;

    function automatic logic hit(input freq_wdt_pkg::reg_req_t r, input logic [4:0] off);
        hit = r.wr && (r.addr == off);
    endfunction

    // Write decode; straps have no write path
    assign wr_ctrl  = hit(reg_req, freq_wdt_pkg::OFF_CTRL);
    assign wr_sel   = hit(reg_req, freq_wdt_pkg::OFF_SELECT);
    assign wr_wdt   = hit(reg_req, freq_wdt_pkg::OFF_WDT);
    assign wr_rec_n = hit(reg_req, freq_wdt_pkg::OFF_REC_N);
    assign wr_rec_m = hit(reg_req, freq_wdt_pkg::OFF_REC_M);
    assign wr_cpu_n = hit(reg_req, freq_wdt_pkg::OFF_CPU_N);
    assign wr_cpu_m = hit(reg_req, freq_wdt_pkg::OFF_CPU_M);

    // Values as they stand after this edge; a load must carry the byte written with it
    assign override_next    = wr_ctrl ? reg_req.wdata[freq_wdt_pkg::BIT_OVERRIDE]
                                      : select_source_override_reg;
    assign rec_src_next     = wr_ctrl ? reg_req.wdata[freq_wdt_pkg::BIT_REC_SRC]
                                      : recovery_source_select_reg;
    assign prog_enable_next = wr_cpu_m ? reg_req.wdata[freq_wdt_pkg::BIT_PROG_EN]
                                       : prog_enable_reg;
    assign select_next      = wr_sel ? reg_req.wdata[4:0] : select_field_reg;
    assign cpu_n_next       = wr_cpu_n ? reg_req.wdata : cpu_divider_numerator_reg;
    assign cpu_m_next       = wr_cpu_m ? reg_req.wdata[6:0] : cpu_divider_denominator_reg;
    assign rec_n_next       = wr_rec_n ? reg_req.wdata : recovery_divider_numerator_reg;
    assign rec_m_next       = wr_rec_m ? reg_req.wdata[6:0] : recovery_divider_denominator_reg;

    // Ratio and gear come from straps or select field
    assign ratio_src = override_next ? select_next : strap_latch_reg;

    // Normal setting: dividers only when enabled; any ratio 50..248 MHz reachable
    assign normal_set.use_dividers = prog_enable_next;
    assign normal_set.ratio_select = ratio_src;
    assign normal_set.numerator    = cpu_n_next;
    assign normal_set.denominator  = cpu_m_next;

    // Recovery setting: straps or recovery dividers
    assign recovery_set.use_dividers = rec_src_next;
    assign recovery_set.ratio_select = rec_src_next ? ratio_src : strap_latch_reg;
    assign recovery_set.numerator    = rec_n_next;
    assign recovery_set.denominator  = rec_m_next;

    // Loads: a divider write, a mode write, or entering recovery
    assign normal_load   = wr_cpu_n || wr_cpu_m || wr_sel || wr_ctrl;
    assign recovery_load = (wr_rec_n || wr_rec_m) && recovery_reg;
    assign load_now      = timeout_evt || (normal_load && !recovery_reg) || recovery_load;
    assign load_set      = (timeout_evt || recovery_reg) ? recovery_set : normal_set;
    assign freq_change   = load_now && (load_set != freq_reg);
    assign pulse_req     = (timeout_evt && reset_on_timeout_enable_reg) ||
                           (freq_change && reset_on_freq_change_enable_reg);

    // Read mux; unused addresses read zero
    assign rd_mux = (reg_req.addr == freq_wdt_pkg::OFF_CTRL) ?
                        {1'b0, reset_on_freq_change_enable_reg, reset_on_timeout_enable_reg,
                         watchdog_unit_select_reg, watchdog_timeout_flag_reg,
                         watchdog_enable_reg, recovery_source_select_reg,
                         select_source_override_reg} :
                    (reg_req.addr == freq_wdt_pkg::OFF_SELECT) ? {3'h0, select_field_reg} :
                    (reg_req.addr == freq_wdt_pkg::OFF_WDT) ? {3'h0, watchdog_timeout_value_reg} :
                    (reg_req.addr == freq_wdt_pkg::OFF_REC_N) ? recovery_divider_numerator_reg :
                    (reg_req.addr == freq_wdt_pkg::OFF_REC_M) ? {1'b0, recovery_divider_denominator_reg} :
                    (reg_req.addr == freq_wdt_pkg::OFF_CPU_N) ? cpu_divider_numerator_reg :
                    (reg_req.addr == freq_wdt_pkg::OFF_CPU_M) ? {prog_enable_reg, cpu_divider_denominator_reg} :
                    (reg_req.addr == freq_wdt_pkg::OFF_STRAPS) ? {strap_latch_reg, 3'h0} : 8'h00;

    assign reg_rdata    = rdata_reg;
    assign freq_out     = freq_reg;
    assign freq_load    = load_reg;
    assign in_recovery  = recovery_reg;
    assign system_reset = sysrst_reg;

    // Straps pass two flops, then latch once after reset release
    always_ff @(posedge clock) begin
        strap_s1_reg <= strap_select_inputs;
        strap_s2_reg <= strap_s1_reg;
        if (!rstn) begin
            strap_done_reg  <= 1'b0;
            strap_latch_reg <= 5'h00;
        end else if (!strap_done_reg) begin
            strap_done_reg  <= 1'b1;
            strap_latch_reg <= strap_s2_reg;
        end
    end

    // Control byte register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            select_source_override_reg      <= freq_wdt_pkg::CTRL_RST[freq_wdt_pkg::BIT_OVERRIDE];
            recovery_source_select_reg      <= freq_wdt_pkg::CTRL_RST[freq_wdt_pkg::BIT_REC_SRC];
            watchdog_enable_reg             <= freq_wdt_pkg::CTRL_RST[freq_wdt_pkg::BIT_WATCHDOG_ENABLE];
            watchdog_unit_select_reg        <= freq_wdt_pkg::CTRL_RST[freq_wdt_pkg::BIT_UNIT_SEL];
            reset_on_timeout_enable_reg     <= freq_wdt_pkg::CTRL_RST[freq_wdt_pkg::BIT_RST_WD];
            reset_on_freq_change_enable_reg <= freq_wdt_pkg::CTRL_RST[freq_wdt_pkg::BIT_RST_FC];
        end else if (wr_ctrl) begin
            select_source_override_reg      <= reg_req.wdata[freq_wdt_pkg::BIT_OVERRIDE];
            recovery_source_select_reg      <= reg_req.wdata[freq_wdt_pkg::BIT_REC_SRC];
            watchdog_enable_reg             <= reg_req.wdata[freq_wdt_pkg::BIT_WATCHDOG_ENABLE];
            watchdog_unit_select_reg        <= reg_req.wdata[freq_wdt_pkg::BIT_UNIT_SEL];
            reset_on_timeout_enable_reg     <= reg_req.wdata[freq_wdt_pkg::BIT_RST_WD];
            reset_on_freq_change_enable_reg <= reg_req.wdata[freq_wdt_pkg::BIT_RST_FC];
        end
    end

    // Sticky flag; a time-out in the clear cycle wins
    always_ff @(posedge clock) begin
        if (!rstn) begin
            watchdog_timeout_flag_reg <= 1'b0;
        end else if (timeout_evt) begin
            watchdog_timeout_flag_reg <= 1'b1;
        end else if (wr_ctrl && reg_req.wdata[freq_wdt_pkg::BIT_WD_FLAG]) begin
            watchdog_timeout_flag_reg <= 1'b0;
        end
    end

    // Data registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            prog_enable_reg                  <= 1'b0;
            select_field_reg                 <= 5'h00;
            watchdog_timeout_value_reg       <= freq_wdt_pkg::TIMEOUT_RST;
            cpu_divider_numerator_reg        <= 8'h00;
            cpu_divider_denominator_reg      <= 7'h00;
            recovery_divider_numerator_reg   <= 8'h00;
            recovery_divider_denominator_reg <= 7'h00;
        end else begin
            if (wr_sel)   select_field_reg <= reg_req.wdata[4:0];
            if (wr_wdt)   watchdog_timeout_value_reg <= reg_req.wdata[4:0];
            if (wr_cpu_n) cpu_divider_numerator_reg <= reg_req.wdata;
            if (wr_cpu_m) begin
                prog_enable_reg             <= reg_req.wdata[freq_wdt_pkg::BIT_PROG_EN];
                cpu_divider_denominator_reg <= reg_req.wdata[6:0];
            end
            if (wr_rec_n) recovery_divider_numerator_reg <= reg_req.wdata;
            if (wr_rec_m) recovery_divider_denominator_reg <= reg_req.wdata[6:0];
        end
    end

    // Recovery mode: entered on time-out, left when the flag is cleared
    always_ff @(posedge clock) begin
        if (!rstn) begin
            recovery_reg <= 1'b0;
        end else if (timeout_evt) begin
            recovery_reg <= 1'b1;
        end else if (wr_ctrl && reg_req.wdata[freq_wdt_pkg::BIT_WD_FLAG]) begin
            recovery_reg <= 1'b0;
        end
    end

    // Output setting and load strobe; recovery follows timeout in one cycle
    always_ff @(posedge clock) begin
        if (!rstn) begin
            freq_reg  <= '0;
            load_reg  <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            load_reg  <= normal_load || recovery_load || timeout_evt;
            rdata_reg <= rd_mux;
            if (load_now) begin
                freq_reg <= load_set;
            end
        end
    end

    // Reset pulse requests
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sysrst_reg <= 1'b0;
        end else begin
            sysrst_reg <= pulse;
        end
    end

    // Entering recovery does not rearm, so one hang gives one time-out
    wdt_counter u_wdt (
        .clock         (clock),
        .rstn          (rstn),
        .enable        (watchdog_enable_reg),
        .arm           (freq_change && !timeout_evt),
        .unit_select   (watchdog_unit_select_reg),
        .timeout_value (watchdog_timeout_value_reg),
        .expired       (timeout_evt),
        .running       (wdt_running)
    );

    reset_pulser u_pulse (
        .clock   (clock),
        .rstn    (rstn),
        .trigger (pulse_req),
        .pulse   (pulse)
    );

    // Checks
    AST_TIMEOUT_SETS_FLAG: assert property (@(posedge clock) disable iff (!rstn)
        timeout_evt |=> watchdog_timeout_flag_reg && recovery_reg)
        else $error("timeout did not set flag");
    AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (!rstn)
        watchdog_timeout_flag_reg && !(wr_ctrl && reg_req.wdata[freq_wdt_pkg::BIT_WD_FLAG])
        |=> watchdog_timeout_flag_reg)
        else $error("flag dropped without clear");
    AST_CLEAR_FLAG: assert property (@(posedge clock) disable iff (!rstn)
        wr_ctrl && reg_req.wdata[freq_wdt_pkg::BIT_WD_FLAG] && !timeout_evt
        |=> !watchdog_timeout_flag_reg)
        else $error("write one did not clear flag");
    AST_WD_RESET: assert property (@(posedge clock) disable iff (!rstn)
        timeout_evt && reset_on_timeout_enable_reg |-> ##2 sysrst_reg [*8])
        else $error("timeout reset pulse missing");
    AST_FC_RESET: assert property (@(posedge clock) disable iff (!rstn)
        freq_change && reset_on_freq_change_enable_reg |-> ##2 sysrst_reg)
        else $error("frequency change reset missing");
    AST_NO_RESET: assert property (@(posedge clock) disable iff (!rstn)
        !pulse && (!timeout_evt || !reset_on_timeout_enable_reg) &&
        (!freq_change || !reset_on_freq_change_enable_reg) |=> ##1 !sysrst_reg)
        else $error("spurious system reset");
    AST_LOAD_CPU: assert property (@(posedge clock) disable iff (!rstn)
        (wr_cpu_n || wr_cpu_m) && !recovery_reg && !timeout_evt |=> freq_load)
        else $error("divider write did not load");
    AST_RECOVERY_SRC: assert property (@(posedge clock) disable iff (!rstn)
        timeout_evt |=> freq_out.use_dividers == $past(recovery_source_select_reg))
        else $error("recovery source wrong");
    AST_WD_STOPPED: assert property (@(posedge clock) disable iff (!rstn)
        !watchdog_enable_reg |=> !wdt_running)
        else $error("watchdog ran while disabled");
    AST_RATIO_SRC: assert property (@(posedge clock) disable iff (!rstn)
        wr_sel && !recovery_reg && !timeout_evt |=> freq_out.ratio_select ==
        ($past(select_source_override_reg) ? $past(reg_req.wdata[4:0]) : strap_latch_reg))
        else $error("ratio source wrong");
endmodule
`default_nettype wire

// ===== prog_freq_watchdog_recovery_tb.sv
// Self-checking bench for frequency select, load and reset pulse logic
`timescale 1ns/10ps
`default_nettype none
module prog_freq_watchdog_recovery_tb;
    localparam logic [4:0] STRAPS = 5'h15;

    logic                        clock;
    logic                        rstn;
    logic [4:0]                  strap_select_inputs;
    freq_wdt_pkg::reg_req_t      reg_req;
    logic [7:0]                  reg_rdata;
    freq_wdt_pkg::freq_setting_t freq_out;
    logic                        freq_load;
    logic                        in_recovery;
    logic                        system_reset;
    int                          n_errors;
    int                          n_checks;
    int                          n;
    logic [7:0]                  rd;

    prog_freq_watchdog_recovery u_prog_freq_watchdog_recovery (
        .clock               (clock),
        .rstn                (rstn),
        .strap_select_inputs (strap_select_inputs),
        .reg_req             (reg_req),
        .reg_rdata           (reg_rdata),
        .freq_out            (freq_out),
        .freq_load           (freq_load),
        .in_recovery         (in_recovery),
        .system_reset        (system_reset)
    );

    smbus_host_model u_smbus_host_model (
        .clock     (clock),
        .reg_req   (reg_req),
        .reg_rdata (reg_rdata)
    );

    // Reference clock, 100 MHz
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // One comparison with case inequality so unknowns fail
    task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Read a byte and compare it
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string msg);
        u_smbus_host_model.read_byte(a, rd);
        chk(rd, exp, msg);
    endtask

    // Waits up to a few cycles for the pulse, then measures its width
    task automatic pulse_width(output int w);
        w = 0;
        for (int i = 0; i < 6 && system_reset !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        while (system_reset === 1'b1 && w < 40) begin
            @(posedge clock);
            #1;
            w++;
        end
    endtask

    // Quiet window: no reset pulse may appear
    task automatic no_pulse(input int cycles);
        for (int i = 0; i < cycles; i++) begin
            @(posedge clock);
            #1;
            chk(system_reset, 1'b0, "unexpected reset pulse");
        end
    endtask

    // Hang guard at 100000 cycles, well above the run length
    initial begin
        #1000000;
        n_errors++;
        $display("[FAIL] t=%0t run timed out", $time);
        complete_run();
    end

    initial begin
        n_errors = 0;
        n_checks = 0;
        rstn = 1'b0;
        strap_select_inputs = STRAPS;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;

        // Reset values and read-only straps
        rd_chk(freq_wdt_pkg::OFF_CTRL, freq_wdt_pkg::CTRL_RST, "ctrl reset");
        rd_chk(freq_wdt_pkg::OFF_CPU_M, 8'h00, "prog enable reset");
        rd_chk(freq_wdt_pkg::OFF_WDT, {3'h0, freq_wdt_pkg::TIMEOUT_RST}, "timeout reset");
        rd_chk(freq_wdt_pkg::OFF_STRAPS, {STRAPS, 3'h0}, "latched straps");
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_STRAPS, 8'h00);
        rd_chk(freq_wdt_pkg::OFF_STRAPS, {STRAPS, 3'h0}, "straps after write");
        u_smbus_host_model.write_byte(5'h08, 8'hff);
        rd_chk(5'h08, 8'h00, "unmapped read");
        $display("test reset_and_map done");

        // Dividers off: straps, then select field under override
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CTRL, 8'h00);
        #1;
        chk(freq_load, 1'b1, "load after ctrl write");
        chk({freq_out.use_dividers, freq_out.ratio_select}, {1'b0, STRAPS}, "strap select");
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_SELECT, 8'h0a);
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CTRL, 8'h01);
        #1;
        chk({freq_out.use_dividers, freq_out.ratio_select}, {1'b0, 5'h0a}, "select field");
        $display("test select_source done");

        // Dividers on, N and M in one burst; gear source follows override
        u_smbus_host_model.write_word(freq_wdt_pkg::OFF_CPU_N, 8'h61, 8'hdd);
        #1;
        chk(freq_load, 1'b1, "load after M write");
        chk(freq_out, {1'b1, 5'h0a, 8'h61, 7'h5d}, "divider setting");
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CTRL, 8'h00);
        #1;
        chk(freq_out, {1'b1, STRAPS, 8'h61, 7'h5d}, "gear from straps");
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CPU_N, 8'h7f);
        #1;
        chk(freq_load, 1'b1, "load after N write");
        chk(freq_out.numerator, 8'h7f, "new numerator");
        $display("test dividers done");

        // Flag write one with no time-out leaves it clear
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CTRL, 8'h48);
        rd_chk(freq_wdt_pkg::OFF_CTRL, 8'h40, "flag clear on write");
        repeat (20) @(posedge clock);
        // Frequency change with reset enabled gives a fixed pulse
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CPU_N, 8'h80);
        #1;
        pulse_width(n);
        chk(n, freq_wdt_pkg::RESET_PULSE_CYC, "change reset width");
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CTRL, 8'h00);
        repeat (20) @(posedge clock);
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CPU_N, 8'h90);
        no_pulse(24);
        $display("test reset_pulse done");

        // Recovery dividers are stored but not applied outside recovery
        u_smbus_host_model.write_word(freq_wdt_pkg::OFF_REC_N, 8'hf5, 8'h2d);
        rd_chk(freq_wdt_pkg::OFF_REC_N, 8'hf5, "recovery N");
        rd_chk(freq_wdt_pkg::OFF_REC_M, 8'h2d, "recovery M");
        chk({in_recovery, freq_out.numerator}, {1'b0, 8'h90}, "normal setting kept");
        $display("test recovery_regs done");

        // Watchdog arms only on a change, stops and reloads when disabled
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CTRL, 8'h36);
        rd_chk(freq_wdt_pkg::OFF_CTRL, 8'h36, "ctrl bits");
        chk(u_prog_freq_watchdog_recovery.wdt_running, 1'b0, "idle before change");
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CPU_N, 8'ha0);
        #1;
        chk(u_prog_freq_watchdog_recovery.wdt_running, 1'b1, "armed by change");
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_CTRL, 8'h00);
        u_smbus_host_model.write_byte(freq_wdt_pkg::OFF_WDT, 8'h03);
        @(posedge clock);
        #1;
        chk(u_prog_freq_watchdog_recovery.wdt_running, 1'b0, "stopped");
        chk(u_prog_freq_watchdog_recovery.u_wdt.count_reg, 5'h03, "reloaded");
        chk(in_recovery, 1'b0, "no recovery without timeout");
        $display("test watchdog_arm done");
        complete_run();
    end
endmodule
`default_nettype wire

// ===== reset_pulser.sv
// Fixed-width system reset pulse generator
`timescale 1ns/10ps
`default_nettype none
module reset_pulser (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic trigger,
    output logic      pulse
);
    logic [7:0] cnt_reg;

    assign pulse = (cnt_reg != 8'h0);

    // Retrigger restarts the full width
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cnt_reg <= 8'h0;
        end else if (trigger) begin
            cnt_reg <= 8'(freq_wdt_pkg::RESET_PULSE_CYC);
        end else if (cnt_reg != 8'h0) begin
            cnt_reg <= cnt_reg - 8'h1;
        end
    end
endmodule
`default_nettype wire

// ===== smbus_host_model.sv
// Host side model: drives byte writes and reads on the register port
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
    input  wire logic                   clock,
    output var freq_wdt_pkg::reg_req_t  reg_req,
    input  wire logic [7:0]             reg_rdata
);
    // Idle request at time zero, no write pending
    initial begin
        reg_req = '0;
    end

    // One byte write, taken at the edge after it is raised
    task automatic write_byte(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clock);
        reg_req.wr <= 1'b0;
    endtask

    // N then M back to back, so only one intermediate load window
    task automatic write_word(input logic [4:0] a, input logic [7:0] n, input logic [7:0] m);
        @(posedge clock);
        reg_req <= '{wr: 1'b1, addr: a, wdata: n};
        @(posedge clock);
        reg_req <= '{wr: 1'b1, addr: a + 5'h01, wdata: m};
        @(posedge clock);
        reg_req.wr <= 1'b0;
    endtask

    // Read data is registered, so it is settled one edge after the address
    task automatic read_byte(input logic [4:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_req.addr <= a;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== wdt_counter.sv
// Watchdog counter with prescaler time base
`timescale 1ns/10ps
`default_nettype none
module wdt_counter (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       enable,
    input  wire logic       arm,
    input  wire logic       unit_select,
    input  wire logic [4:0] timeout_value,
    output logic            expired,
    output logic            running
);
    logic [31:0] pre_reg;
    logic [4:0]  count_reg;
    logic        run_reg;
    logic        exp_reg;
    logic [31:0] unit_cyc;
    logic        tick;

    // Prescaler limit from the unit select
    assign unit_cyc = unit_select ? freq_wdt_pkg::UNIT_LONG_CYC : freq_wdt_pkg::UNIT_SHORT_CYC;
    assign tick     = run_reg && (pre_reg == unit_cyc - 32'h1);
    assign expired  = exp_reg;
    assign running  = run_reg;

    // Disabled stops and reloads; armed only by a frequency change
    always_ff @(posedge clock) begin
        exp_reg <= 1'b0;
        if (!rstn || !enable) begin
            pre_reg   <= 32'h0;
            count_reg <= timeout_value;
            run_reg   <= 1'b0;
        end else if (arm) begin
            pre_reg   <= 32'h0;
            count_reg <= timeout_value;
            run_reg   <= 1'b1;
        end else if (tick) begin
            pre_reg <= 32'h0;
            if (count_reg <= 5'h1) begin
                count_reg <= 5'h0;
                run_reg   <= 1'b0;
                exp_reg   <= 1'b1;
            end else begin
                count_reg <= count_reg - 5'h1;
            end
        end else if (run_reg) begin
            pre_reg <= pre_reg + 32'h1;
        end
    end
endmodule
`default_nettype wire
